// file: inc/cpwm_regs.svh
// Register offsets, field positions, reset values and encodings for the complementary PWM / phase counter.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef CPWM_REGS_SVH
`define CPWM_REGS_SVH

// ============================================================
// Register byte offsets
`define CPWM_OFF_START      12'h000
`define CPWM_OFF_FUNC       12'h004
`define CPWM_OFF_OUTCTL     12'h008
`define CPWM_OFF_CH3_CNT    12'h00c
`define CPWM_OFF_CH4_CNT    12'h010
`define CPWM_OFF_CH3_LIM    12'h014
`define CPWM_OFF_CH3_TR     12'h018
`define CPWM_OFF_CH4_TRA    12'h01c
`define CPWM_OFF_CH4_TRB    12'h020
`define CPWM_OFF_BUF3       12'h024
`define CPWM_OFF_BUF4A      12'h028
`define CPWM_OFF_BUF4B      12'h02c
`define CPWM_OFF_STATUS     12'h030
`define CPWM_OFF_CH2_CNT    12'h034
`define CPWM_OFF_CH2_CTL    12'h038
`define CPWM_OFF_CH2_GA     12'h03c
`define CPWM_OFF_CH2_GB     12'h040

// ============================================================
// Field positions
`define CPWM_RUN_CH2_BIT    2
`define CPWM_RUN_CH3_BIT    3
`define CPWM_RUN_CH4_BIT    4
`define CPWM_CMD_LSB        0
`define CPWM_BUFEN_BIT      2
`define CPWM_PHASE_BIT      3
`define CPWM_OUTPUT_LEVEL_SELECT_BIT       0
`define CPWM_OLS4_BIT       1
`define CPWM_ST_MATCHA3     0
`define CPWM_ST_OVF4        1
`define CPWM_ST_MATCHA2     2
`define CPWM_ST_MATCHB2     3
`define CPWM_ST_OVF2        4
`define CPWM_CCLR_LSB       0

// ============================================================
// Reset values and encodings
`define CPWM_CMD_COMPL      2'b10
`define CPWM_OUTCTL_RST     2'b11
`define CPWM_CNT_RST        16'h0000
`define CPWM_GR_RST         16'hffff
`define CPWM_CNT_MAX        16'hffff
`define CPWM_CCLR_A         2'b01
`define CPWM_CCLR_B         2'b10

`endif

// file: inc/cpwm_pkg.sv
// Types shared by the complementary PWM / phase counter design.
// Assumes nothing beyond the register header.
package cpwm_pkg;
    typedef logic [15:0] cpwm_cnt_type;
    typedef enum logic [1:0] {
        CPWM_PH_IDLE,
        CPWM_PH_COUNT
    } cpwm_phase_state_type;
endpackage

// file: hw/cpwm_quad.sv
// Quadrature decoder for channel 2: one count step per edge of either input.
// Assumes both inputs already synchronous to clk.
`timescale 1ns/1ps
module cpwm_quad
    import cpwm_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic quad_in_a,
    input  wire logic quad_in_b,
    output logic      step,
    output logic      up
);
    logic a_q;
    logic b_q;
    cpwm_phase_state_type state_q;

    wire a_rise = quad_in_a & ~a_q;
    wire a_fall = ~quad_in_a & a_q;
    wire b_rise = quad_in_b & ~b_q;
    wire b_fall = ~quad_in_b & b_q;
    // ============================================================
    // Direction table; both edges of both inputs count
    wire up_ev  = (b_rise & ~quad_in_a) | (a_rise & quad_in_b) | (b_fall & quad_in_a) | (a_fall & ~quad_in_b);
    wire dn_ev  = (b_rise & quad_in_a) | (a_rise & ~quad_in_b) | (b_fall & ~quad_in_a) | (a_fall & quad_in_b);

    // First cycle after enable only takes the levels, no false edge
    wire live   = enable & (state_q == CPWM_PH_COUNT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_q     <= 1'b0;
            b_q     <= 1'b0;
            state_q <= CPWM_PH_IDLE;
        end else begin
            a_q <= quad_in_a;
            b_q <= quad_in_b;
            case (state_q)
                CPWM_PH_IDLE:  state_q <= enable ? CPWM_PH_COUNT : CPWM_PH_IDLE;
                CPWM_PH_COUNT: state_q <= enable ? CPWM_PH_COUNT : CPWM_PH_IDLE;
                default:       state_q <= CPWM_PH_IDLE;
            endcase
        end
    end

    assign step = live & (up_ev | dn_ev);
    assign up   = up_ev;
endmodule

// file: hw/cpwm_top.sv
// Complementary PWM on channels 3/4 and phase counting on channel 2, APB register slave.
// Assumes a single 125 MHz clock, ch3/ch4 counters stepping once per clock, quadrature inputs synchronous.
// Contract
// - Compl mode drives three complementary output pairs
// - Both counters count up and down
// - Each transition register drives its pair
// - Reverse at limit match and underflow
// - Outputs change on counter/transition matches
// - Transition above limit gives 0/100 percent
// - Overshoot/undershoot before reversing; flags follow
// - Match A flag only while counting up
// - Overflow flag only on ch4 underflow
// - Buffers load at top match, underflow
// - Channel 2 counts quadrature, ignores prescaler
// - Channel 2 clear, compare, flags stay active
// - Count every edge of both inputs
// - Level select bits invert outputs
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "cpwm_regs.svh"
module cpwm_top
    import cpwm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        quad_in_a,
    input  wire logic        quad_in_b,
    output logic             pwm_out1,
    output logic             pwm_out1_n,
    output logic             pwm_out2,
    output logic             pwm_out2_n,
    output logic             pwm_out3,
    output logic             pwm_out3_n
);
    // ============================================================
    // Registers
    logic [4:0]   run_q;
    logic [3:0]   func_q;
    logic [1:0]   outctl_q;
    cpwm_cnt_type c3_q;
    cpwm_cnt_type c4_q;
    cpwm_cnt_type c2_q;
    logic         down_q;
    cpwm_cnt_type lim_q;
    cpwm_cnt_type tr_q [3];
    cpwm_cnt_type buf_q [3];
    cpwm_cnt_type ga2_q;
    cpwm_cnt_type gb2_q;
    logic [1:0]   cclr_q;
    logic [4:0]   st_q;
    logic [2:0]   pair_q;
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;
    logic [5:0]   pins_q;

    // ============================================================
    // APB decode; answer one cycle into the access phase
    wire acc    = psel & penable & ~pready_q;
    wire wr     = acc & pwrite;
    wire [15:0] wd = pwdata[15:0];
    wire hit    = (paddr[1:0] == 2'b00) && (paddr <= `CPWM_OFF_CH2_GB);
    wire wr_run = wr && paddr == `CPWM_OFF_START;
    wire wr_fn  = wr && paddr == `CPWM_OFF_FUNC;
    wire wr_oc  = wr && paddr == `CPWM_OFF_OUTCTL;
    wire wr_c3  = wr && paddr == `CPWM_OFF_CH3_CNT;
    wire wr_c4  = wr && paddr == `CPWM_OFF_CH4_CNT;
    wire wr_lim = wr && paddr == `CPWM_OFF_CH3_LIM;
    wire wr_st  = wr && paddr == `CPWM_OFF_STATUS;
    wire wr_c2  = wr && paddr == `CPWM_OFF_CH2_CNT;
    wire wr_cl  = wr && paddr == `CPWM_OFF_CH2_CTL;
    wire wr_ga  = wr && paddr == `CPWM_OFF_CH2_GA;
    wire wr_gb  = wr && paddr == `CPWM_OFF_CH2_GB;

    // ============================================================
    // Complementary counter control
    wire compl  = func_q[`CPWM_CMD_LSB +: 2] == `CPWM_CMD_COMPL;
    wire bufen  = func_q[`CPWM_BUFEN_BIT];
    wire run34  = compl & run_q[`CPWM_RUN_CH3_BIT] & run_q[`CPWM_RUN_CH4_BIT];
    // Top match is taken while c3 leaves the limit value, so c3 overshoots to limit+1 first
    wire top    = run34 & ~down_q & (c3_q == lim_q);
    // Underflow: c4 steps 0000 -> ffff, then turns and climbs
    wire bottom = run34 & down_q & (c4_q == `CPWM_CNT_RST);
    wire dir_dn = top ? 1'b1 : (bottom ? 1'b0 : down_q);
    // Counters keep stepping in the old direction on the reversal cycle
    wire cpwm_cnt_type c3_d = down_q ? c3_q - 16'h0001 : c3_q + 16'h0001;
    wire cpwm_cnt_type c4_d = down_q ? c4_q - 16'h0001 : c4_q + 16'h0001;

    // Per-pair match: pair 1 leads on c3 then c4; the others follow the same sequence
    logic [2:0] set_ev;
    logic [2:0] clr_ev;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_pair
            // A value above the limit never matches, pair stays fixed
            wire in_rng = tr_q[g] <= lim_q;
            wire m4     = run34 & in_rng & (c4_q == tr_q[g]);
            // Up: c3 match ends the negative phase, c4 match starts positive
            // Down: c4 match ends positive, c3 match starts negative
            assign set_ev[g] = ~down_q & m4;
            assign clr_ev[g] = down_q & m4;
        end
    endgenerate
    // Complement leg is cut by c3 going up and restored by c3 going down
    logic [2:0] nset_ev;
    logic [2:0] nclr_ev;
    generate
        for (g = 0; g < 3; g++) begin : gen_npair
            wire in_rng = tr_q[g] <= lim_q;
            wire m3     = run34 & in_rng & (c3_q == tr_q[g]);
            assign nclr_ev[g] = ~down_q & m3;
            assign nset_ev[g] = down_q & m3;
        end
    endgenerate

    // Leg state: bit g positive leg, pair_q is held as positive active; complement tracked separately
    logic [2:0] npair_q;
    wire [2:0] pair_d  = (pair_q | set_ev) & ~clr_ev;
    wire [2:0] npair_d = (npair_q | nset_ev) & ~nclr_ev;
    // Level select inverts active level per channel
    wire output_level_select = outctl_q[`CPWM_OUTPUT_LEVEL_SELECT_BIT];
    wire ols4 = outctl_q[`CPWM_OLS4_BIT];
    wire lvl1   = pair_q[0] ~^ output_level_select;
    wire lvl1_n = npair_q[0] ~^ output_level_select;
    wire lvl2   = pair_q[1] ~^ ols4;
    wire lvl2_n = npair_q[1] ~^ ols4;
    wire lvl3   = pair_q[2] ~^ ols4;
    wire lvl3_n = npair_q[2] ~^ ols4;
    // Outside the mode every pin rests low
    wire [5:0] pins_d = compl ? {lvl3, lvl3_n, lvl2, lvl2_n, lvl1, lvl1_n} : 6'h00;

    // ============================================================
    // Channel 2 phase counting
    logic q_step;
    logic q_up;
    wire phase = func_q[`CPWM_PHASE_BIT] & run_q[`CPWM_RUN_CH2_BIT];
    cpwm_quad u_quad (
        .clk       (clk),
        .rst       (rst),
        .enable    (phase),
        .quad_in_a (quad_in_a),
        .quad_in_b (quad_in_b),
        .step      (q_step),
        .up        (q_up)
    );
    // Prescaler and edge settings have no effect here; only the decoder steps the counter
    wire ma2 = q_step & (c2_q == ga2_q);
    wire mb2 = q_step & (c2_q == gb2_q);
    wire wrap2 = q_step & (q_up ? c2_q == `CPWM_CNT_MAX : c2_q == `CPWM_CNT_RST);
    wire clr2 = (ma2 & cclr_q == `CPWM_CCLR_A) | (mb2 & cclr_q == `CPWM_CCLR_B);
    wire cpwm_cnt_type c2_d = clr2 ? `CPWM_CNT_RST :
        (q_step ? (q_up ? c2_q + 16'h0001 : c2_q - 16'h0001) : c2_q);

    // ============================================================
    // Status flags
    // Hardware set wins over a software clear in the same cycle
    wire [4:0] st_set = {wrap2, mb2, ma2, bottom, top};
    wire [4:0] st_d   = (wr_st ? (st_q & pwdata[4:0]) : st_q) | st_set;

    // ============================================================
    // Read mux
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        case (paddr)
            `CPWM_OFF_START:   rd = {27'h0, run_q};
            `CPWM_OFF_FUNC:    rd = {28'h0, func_q};
            `CPWM_OFF_OUTCTL:  rd = {30'h0, outctl_q};
            `CPWM_OFF_CH3_CNT: rd = {16'h0, c3_q};
            `CPWM_OFF_CH4_CNT: rd = {16'h0, c4_q};
            `CPWM_OFF_CH3_LIM: rd = {16'h0, lim_q};
            `CPWM_OFF_CH3_TR:  rd = {16'h0, tr_q[0]};
            `CPWM_OFF_CH4_TRA: rd = {16'h0, tr_q[1]};
            `CPWM_OFF_CH4_TRB: rd = {16'h0, tr_q[2]};
            `CPWM_OFF_BUF3:    rd = {16'h0, buf_q[0]};
            `CPWM_OFF_BUF4A:   rd = {16'h0, buf_q[1]};
            `CPWM_OFF_BUF4B:   rd = {16'h0, buf_q[2]};
            `CPWM_OFF_STATUS:  rd = {27'h0, st_q};
            `CPWM_OFF_CH2_CNT: rd = {16'h0, c2_q};
            `CPWM_OFF_CH2_CTL: rd = {30'h0, cclr_q};
            `CPWM_OFF_CH2_GA:  rd = {16'h0, ga2_q};
            `CPWM_OFF_CH2_GB:  rd = {16'h0, gb2_q};
            default:           rd = 32'h0000_0000;
        endcase
    end

    // ============================================================
    // Transition registers and their buffers
    generate
        for (g = 0; g < 3; g++) begin : gen_tr
            wire wr_tr = wr && paddr == (`CPWM_OFF_CH3_TR + 12'(4 * g));
            wire wr_bf = wr && paddr == (`CPWM_OFF_BUF3 + 12'(4 * g));
            // Direct writes are honoured but glitch-prone mid-cycle; buffers are the safe path
            wire xfer  = bufen & (top | bottom);
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    tr_q[g]  <= `CPWM_GR_RST;
                    buf_q[g] <= `CPWM_GR_RST;
                end else begin
                    tr_q[g]  <= wr_tr ? wd : (xfer ? buf_q[g] : tr_q[g]);
                    buf_q[g] <= wr_bf ? wd : buf_q[g];
                end
            end
        end
    endgenerate

    // ============================================================
    // Counters and control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q    <= 5'h00;
            func_q   <= 4'h0;
            outctl_q <= `CPWM_OUTCTL_RST;
            lim_q    <= `CPWM_GR_RST;
            ga2_q    <= `CPWM_GR_RST;
            gb2_q    <= `CPWM_GR_RST;
            cclr_q   <= 2'b00;
            st_q     <= 5'h00;
        end else begin
            run_q    <= wr_run ? pwdata[4:0] : run_q;
            func_q   <= wr_fn ? pwdata[3:0] : func_q;
            outctl_q <= wr_oc ? pwdata[1:0] : outctl_q;
            lim_q    <= wr_lim ? wd : lim_q;
            ga2_q    <= wr_ga ? wd : ga2_q;
            gb2_q    <= wr_gb ? wd : gb2_q;
            cclr_q   <= wr_cl ? pwdata[1:0] : cclr_q;
            st_q     <= st_d;
        end
    end

    // Software presets win over a step; the margin only holds if both counters are written while stopped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c3_q   <= `CPWM_CNT_RST;
            c4_q   <= `CPWM_CNT_RST;
            down_q <= 1'b0;
        end else begin
            c3_q   <= wr_c3 ? wd : (run34 ? c3_d : c3_q);
            c4_q   <= wr_c4 ? wd : (run34 ? c4_d : c4_q);
            down_q <= run34 ? dir_dn : 1'b0;
        end
    end

    // Channel 2 moves only on decoded steps or a software write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c2_q <= `CPWM_CNT_RST;
        end else begin
            c2_q <= wr_c2 ? wd : c2_d;
        end
    end

    // ============================================================
    // Pins and bus response
    // Positive legs start off and complements on, so no overlap at mode entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pair_q  <= 3'b000;
            npair_q <= 3'b111;
            pins_q  <= 6'h00;
        end else begin
            pair_q  <= run34 ? pair_d : 3'b000;
            npair_q <= run34 ? npair_d : 3'b111;
            pins_q  <= pins_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= acc ? rd : 32'h0000_0000;
            pready_q  <= acc;
            pslverr_q <= acc & ~hit;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign pwm_out1_n = pins_q[0];
    assign pwm_out1   = pins_q[1];
    assign pwm_out2_n = pins_q[2];
    assign pwm_out2   = pins_q[3];
    assign pwm_out3_n = pins_q[4];
    assign pwm_out3   = pins_q[5];
endmodule

// file: tb/cpwm_enc.sv
// Partner model: quadrature encoder that feeds the channel 2 phase inputs.
// Assumes one step request per idle period; steps asked while busy are dropped.
`timescale 1ns/1ps
module cpwm_enc
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic go,
    input  wire logic up,
    output logic      quad_in_a,
    output logic      quad_in_b,
    output logic      busy
);
    // ============================================================
    // Phase state
    logic [1:0] ph_q;
    logic [1:0] hold_q;

    // Up order on (a,b) is 00 01 11 10, so one phase change per step
    assign quad_in_a = ph_q[1];
    assign quad_in_b = ph_q[1] ^ ph_q[0];
    assign busy      = hold_q != 2'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_q   <= 2'h0;
            hold_q <= 2'h0;
        end else if (go && !busy) begin
            ph_q   <= up ? ph_q + 2'h1 : ph_q - 2'h1;
            hold_q <= 2'h3;
        end else if (busy) begin
            hold_q <= hold_q - 2'h1;
        end
    end
endmodule

// file: tb/cpwm_top_properties.sv
// Checker for the APB slave handshake and the complementary output pairs.
// Assumes the level select register sits at the output control offset, reset 11.
`timescale 1ns/1ps
`include "cpwm_regs.svh"
module cpwm_chk
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        pwm_out1,
    input  wire logic        pwm_out1_n,
    input  wire logic        pwm_out2,
    input  wire logic        pwm_out2_n,
    input  wire logic        pwm_out3,
    input  wire logic        pwm_out3_n
);
    // ============================================================
    // Level select shadow
    logic [1:0] lvl_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_q <= 2'h3;
        end else if (psel && penable && !pready && pwrite && paddr == `CPWM_OFF_OUTCTL) begin
            lvl_q <= pwdata[1:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ============================================================
    // Handshake
    a_ready_timing: assert property (psel && penable && !pready |=> pready) else $error("late ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("ready without access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
    a_err_decode: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 12'h040)
        && (!pslverr || prdata == 32'h0)) else $error("bad error response");

    // ============================================================
    // Active high legs of a pair never overlap; a level change lags one cycle
    a_pair1_gap: assert property (lvl_q[0] && $past(lvl_q[0]) |-> !(pwm_out1 && pwm_out1_n))
        else $error("pair 1 overlap");
    a_pair2_gap: assert property (lvl_q[1] && $past(lvl_q[1]) |-> !(pwm_out2 && pwm_out2_n))
        else $error("pair 2 overlap");
    a_pair3_gap: assert property (lvl_q[1] && $past(lvl_q[1]) |-> !(pwm_out3 && pwm_out3_n))
        else $error("pair 3 overlap");

    c_err: cover property (pready && pslverr);
    c_pair1: cover property ($rose(pwm_out1));
    c_pair3: cover property ($rose(pwm_out3_n));
endmodule

bind cpwm_top cpwm_chk chk_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pwm_out1, .pwm_out1_n, .pwm_out2, .pwm_out2_n, .pwm_out3, .pwm_out3_n);

// file: tb/cpwm_top_bench.sv
// Self-checking bench: APB register sequences for complementary PWM and phase counting.
// Assumes the encoder partner model and the bound checker.
`timescale 1ns/1ps
`include "cpwm_regs.svh"
module cpwm_top_bench;
    import cpwm_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, qa, qb, go = 1'b0, dir = 1'b0, ebusy, inv_on = 1'b0;
    logic        pwm_out1, pwm_out1_n, pwm_out2, pwm_out2_n, pwm_out3, pwm_out3_n;
    int          n_fail = 0, checked = 0, n1 = 0, n2 = 0, n3 = 0, nlow = 0;

    always #4 clk = ~clk;

    cpwm_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .quad_in_a(qa),
        .quad_in_b(qb), .pwm_out1(pwm_out1), .pwm_out1_n(pwm_out1_n), .pwm_out2(pwm_out2),
        .pwm_out2_n(pwm_out2_n), .pwm_out3(pwm_out3), .pwm_out3_n(pwm_out3_n));
    cpwm_enc enc (.clk(clk), .rst(rst), .go(go), .up(dir), .quad_in_a(qa), .quad_in_b(qb), .busy(ebusy));

    // ============================================================
    // Pin monitors
    always @(posedge pwm_out1) n1++;
    always @(posedge pwm_out2) n2++;
    always @(pwm_out3 or pwm_out3_n) n3++;
    always @(posedge clk) if (inv_on && !pwm_out1 && !pwm_out1_n) nlow++;

    task automatic close_out;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen at an edge, then releases it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            close_out();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
    endtask

    // One encoder step at a time, waiting out its minimum level time
    task automatic steps(input logic u, input int n);
        int k;
        repeat (n) begin
            go <= 1'b1;
            dir <= u;
            @(posedge clk);
            go <= 1'b0;
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (ebusy !== 1'b0 && k < 10);
            if (k >= 10) begin
                n_fail++;
                close_out();
            end
        end
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(`CPWM_OFF_OUTCTL, 32'h3);
        apb(1'b1, 12'h015, 32'h5, rd, er);
        chk({31'h0, er}, 32'h1);
        rdc(`CPWM_OFF_CH3_LIM, 32'hffff);
        apb(1'b0, 12'h044, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        // Complementary mode, pair 3 parked above the limit; no transition below the margin
        wr(`CPWM_OFF_CH3_CNT, 32'h2);
        wr(`CPWM_OFF_CH4_CNT, 32'h0);
        wr(`CPWM_OFF_CH3_LIM, 32'h9);
        wr(`CPWM_OFF_CH3_TR, 32'h5);
        wr(`CPWM_OFF_CH4_TRA, 32'h4);
        wr(`CPWM_OFF_CH4_TRB, 32'h14);
        wr(`CPWM_OFF_BUF3, 32'h5);
        wr(`CPWM_OFF_BUF4A, 32'h4);
        wr(`CPWM_OFF_BUF4B, 32'h14);
        wr(`CPWM_OFF_STATUS, 32'h0);
        wr(`CPWM_OFF_FUNC, 32'h6);
        wr(`CPWM_OFF_START, 32'h18);
        repeat (20) @(posedge clk);
        n1 = 0;
        n2 = 0;
        n3 = 0;
        repeat (100) @(posedge clk);
        chk({31'h0, n1 > 1}, 32'h1);
        chk({31'h0, n2 > 1}, 32'h1);
        chk(n3, 32'h0);
        apb(1'b0, `CPWM_OFF_STATUS, 32'h0, rd, er);
        chk(rd & 32'h3, 32'h3);
        // Both the parked and the new value stay clear of both reversal bands
        wr(`CPWM_OFF_BUF4B, 32'h6);
        repeat (60) @(posedge clk);
        rdc(`CPWM_OFF_CH4_TRB, 32'h6);
        n3 = 0;
        repeat (60) @(posedge clk);
        chk({31'h0, n3 > 1}, 32'h1);
        wr(`CPWM_OFF_OUTCTL, 32'h0);
        repeat (3) @(posedge clk);
        inv_on <= 1'b1;
        repeat (80) @(posedge clk);
        inv_on <= 1'b0;
        chk(nlow, 32'h0);
        wr(`CPWM_OFF_FUNC, 32'h0);
        repeat (2) @(posedge clk);
        wr(`CPWM_OFF_START, 32'h0);
        chk({26'h0, pwm_out1, pwm_out1_n, pwm_out2, pwm_out2_n, pwm_out3, pwm_out3_n}, 32'h0);
        // Phase counting on channel 2
        wr(`CPWM_OFF_CH2_CNT, 32'h0);
        wr(`CPWM_OFF_CH2_GA, 32'h3);
        wr(`CPWM_OFF_STATUS, 32'h0);
        wr(`CPWM_OFF_FUNC, 32'h8);
        wr(`CPWM_OFF_START, 32'h4);
        steps(1'b1, 5);
        rdc(`CPWM_OFF_CH2_CNT, 32'h5);
        steps(1'b0, 7);
        rdc(`CPWM_OFF_CH2_CNT, 32'hfffe);
        apb(1'b0, `CPWM_OFF_STATUS, 32'h0, rd, er);
        chk({30'h0, rd[4], rd[2]}, 32'h3);
        close_out();
    end
endmodule
